// ===== cpw_channel.sv
// pwm output channel with two selectable time bases and a register port
// assumes a synchronous master with one-cycle strobes, read data one cycle later
// Behaviour
// [RULE1] pwm mode drives the output pin with up to 10-bit duty resolution
// [RULE2] software clears the port g direction bit so the pin is an output
// [RULE3] control written to zero forces the pwm latch low, port latch untouched
// [RULE4] period is (period register + 1) times 4 oscillator periods times prescale
// [RULE5] after count equals period, next increment clears the count
// [RULE6] at rollover output goes high unless duty is zero
// [RULE7] at rollover duty byte copies into the hidden compare byte
// [RULE8] output high for duty part of period, low for the rest
// [RULE9] control resets to zero; duty bytes unknown, kept over soft resets
// [RULE10] top two control bits read zero and ignore writes
// [RULE11] duty is master byte over control bits five and four
// [RULE12] output cleared when latched duty matches count with two fine bits
// [RULE13] duty longer than period never clears the output
// [RULE14] in pwm mode the slave byte is readable, not writable
// [RULE15] duty writes any time, take effect at next rollover
//
// The implementer's own choices: the address map and the address-and-strobe port.
`default_nettype none
`include "cpw_defines.svh"
module cpw_channel (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic por_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic pwm_output_pin_out
);
  logic [7:0] duty_master_q;
  logic [7:0] duty_slave_q;
  logic [1:0] duty_lo_latch_q;
  logic [7:0] control_q;
  logic [7:0] period_a_q;
  logic [7:0] period_b_q;
  logic [7:0] tb_cfg_q;
  logic pwm_q;
  cpw_pkg::cpw_state_t state_q;
  cpw_pkg::cpw_state_t state_d;
  logic [7:0] count_a;
  logic [7:0] count_b;
  logic [1:0] fine_a;
  logic [1:0] fine_b;
  logic roll_a;
  logic roll_b;
  logic [7:0] count_sel;
  logic [1:0] fine_sel;
  logic roll_sel;
  logic pwm_mode;
  logic [9:0] duty_next;
  logic [9:0] duty_live;
  logic match;
  logic sel_b;
  logic roll_q;

  assign sel_b = tb_cfg_q[`CPW_TBCFG_SEL_BIT];
  assign pwm_mode = (control_q[`CPW_MODE_PWM_MSB:`CPW_MODE_PWM_LSB] == `CPW_MODE_PWM_VAL);

  // both time bases share enable and prescale; only one feeds the channel
  cpw_time_base u_tb_a (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(tb_cfg_q[`CPW_TBCFG_ON_BIT]),
    .prescale_in(tb_cfg_q[`CPW_TBCFG_PS_MSB:`CPW_TBCFG_PS_LSB]),
    .period_in(period_a_q),
    .count_out(count_a),
    .fine_out(fine_a),
    .rollover_out(roll_a)
  );
  cpw_time_base u_tb_b (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(tb_cfg_q[`CPW_TBCFG_ON_BIT]),
    .prescale_in(tb_cfg_q[`CPW_TBCFG_PS_MSB:`CPW_TBCFG_PS_LSB]),
    .period_in(period_b_q),
    .count_out(count_b),
    .fine_out(fine_b),
    .rollover_out(roll_b)
  );

  assign count_sel = sel_b ? count_b : count_a; // see [RULE4]
  assign fine_sel = sel_b ? fine_b : fine_a;
  assign roll_sel = sel_b ? roll_b : roll_a;

  assign duty_next = {duty_master_q,
    control_q[`CPW_CTRL_DCLO_MSB:`CPW_CTRL_DCLO_LSB]}; // see [RULE11]
  assign duty_live = {duty_slave_q, duty_lo_latch_q};
  assign match = ({count_sel, fine_sel} == duty_live); // see [RULE12] [RULE13]

  // control: cleared by reset_in but not by por_in, top bits never stored
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      control_q <= `CPW_CTRL_RESET; // see [RULE9]
    end else if (wr_in && addr_in == `CPW_ADDR_CONTROL) begin
      control_q <= wdata_in & `CPW_CTRL_IMPL_MASK; // see [RULE10]
    end
  end

  // duty bytes have no reset: unknown at power up, kept over soft resets
  always_ff @(posedge clk_in) begin
    if (wr_in && addr_in == `CPW_ADDR_DUTY_MASTER) begin
      duty_master_q <= wdata_in; // see [RULE15]
    end
  end

  always_ff @(posedge clk_in) begin
    if (pwm_mode && roll_sel) begin
      duty_slave_q <= duty_master_q; // see [RULE7]
      duty_lo_latch_q <= control_q[`CPW_CTRL_DCLO_MSB:`CPW_CTRL_DCLO_LSB];
    end else if (!pwm_mode && wr_in && addr_in == `CPW_ADDR_DUTY_SLAVE) begin
      duty_slave_q <= wdata_in; // see [RULE14]
    end
  end

  // period and time base registers; reset_in restores them, por_in does not
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      period_a_q <= `CPW_PERIOD_RESET;
      period_b_q <= `CPW_PERIOD_RESET;
      tb_cfg_q <= `CPW_TBCFG_RESET;
    end else begin
      if (wr_in && addr_in == `CPW_ADDR_PERIOD_A) begin
        period_a_q <= wdata_in;
      end
      if (wr_in && addr_in == `CPW_ADDR_PERIOD_B) begin
        period_b_q <= wdata_in;
      end
      if (wr_in && addr_in == `CPW_ADDR_TB_CONFIG) begin
        tb_cfg_q <= wdata_in;
      end
    end
  end

  // rollover delayed one edge: clearing lags the match by one edge too,
  // so the high time equals the duty count exactly
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      roll_q <= 1'b0;
    end else begin
      roll_q <= pwm_mode && roll_sel; // see [RULE6]
    end
  end

  // output state machine
  always_comb begin
    case (state_q)
      cpw_pkg::CPW_OFF: begin
        if (pwm_mode && roll_q) begin
          state_d = (duty_live != 10'h000) ? cpw_pkg::CPW_HIGH : cpw_pkg::CPW_LOW;
        end else begin
          state_d = cpw_pkg::CPW_OFF;
        end
      end
      cpw_pkg::CPW_HIGH, cpw_pkg::CPW_LOW: begin
        if (!pwm_mode) begin
          state_d = cpw_pkg::CPW_OFF; // see [RULE3]
        end else if (roll_q) begin
          // duty copied at rollover is live here
          state_d = (duty_live != 10'h000) ? cpw_pkg::CPW_HIGH : cpw_pkg::CPW_LOW; // see [RULE6]
        end else if (state_q == cpw_pkg::CPW_HIGH && match) begin
          state_d = cpw_pkg::CPW_LOW; // see [RULE8]
        end else begin
          state_d = state_q;
        end
      end
      default: state_d = cpw_pkg::CPW_OFF;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= cpw_pkg::CPW_OFF;
      pwm_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pwm_q <= (state_d == cpw_pkg::CPW_HIGH); // see [RULE1]
    end
  end

  assign pwm_output_pin_out = pwm_q;

  // read port: data in the cycle after the strobe only
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `CPW_ADDR_DUTY_MASTER: rdata_out <= duty_master_q;
        `CPW_ADDR_DUTY_SLAVE: rdata_out <= duty_slave_q;
        `CPW_ADDR_CONTROL: rdata_out <= control_q & `CPW_CTRL_IMPL_MASK;
        `CPW_ADDR_PERIOD_A: rdata_out <= period_a_q;
        `CPW_ADDR_PERIOD_B: rdata_out <= period_b_q;
        `CPW_ADDR_TB_CONFIG: rdata_out <= tb_cfg_q;
        `CPW_ADDR_STATUS: rdata_out <= sel_b ? count_b : count_a;
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // por_in is accepted for system wiring; no register here needs it
  logic unused_por;
  assign unused_por = por_in;

  AST_CTRL_TOP_ZERO: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE10]
    control_q[7:6] == 2'h0) else $error("control top bits set");
  AST_OFF_LOW: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE3]
    !pwm_mode |=> !pwm_output_pin_out) else $error("pin high outside pwm mode");
  // rollover with nonzero duty while the mode stays on
  sequence s_roll_set;
    pwm_mode && roll_sel && duty_next != 10'h000 ##1 pwm_mode;
  endsequence
  sequence s_ctrl_clear;
    wr_in && addr_in == `CPW_ADDR_CONTROL && wdata_in == `CPW_CTRL_RESET;
  endsequence
  AST_ROLL_HIGH: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE6]
    s_roll_set |=> pwm_output_pin_out)
    else $error("pin not set at rollover");
  AST_CLEAR_LOW: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE3]
    s_ctrl_clear |=> ##1 !pwm_output_pin_out)
    else $error("pin high after control cleared");
  AST_ROLL_DELAY: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE6]
    pwm_mode && roll_sel |=> roll_q)
    else $error("rollover not registered");
  AST_PIN_STATE: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE1]
    pwm_output_pin_out == (state_q == cpw_pkg::CPW_HIGH))
    else $error("pin differs from state");
  AST_ZERO_DUTY: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE6]
    pwm_mode && roll_sel && duty_next == 10'h000 |=> ##1 !pwm_output_pin_out)
    else $error("pin set with zero duty");
  AST_DUTY_COPY: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE7]
    pwm_mode && roll_sel |=> duty_live == $past(duty_next))
    else $error("duty not latched at rollover");
  AST_MATCH_LOW: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE12]
    pwm_mode && !roll_q && match && state_q == cpw_pkg::CPW_HIGH |=> !pwm_output_pin_out)
    else $error("pin not cleared on match");
  AST_SLAVE_RO: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE14]
    pwm_mode && !roll_sel && !$past(roll_sel) |=> $stable(duty_slave_q))
    else $error("slave byte changed in pwm mode");
  AST_COUNT_CLEAR: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE5]
    roll_a |=> count_a == 8'h00) else $error("count not cleared");
  AST_HOLD_HIGH: assert property (@(posedge clk_in) disable iff (reset_in) // see [RULE13]
    pwm_mode && state_q == cpw_pkg::CPW_HIGH && !match && !roll_q
    |=> state_q == cpw_pkg::CPW_HIGH)
    else $error("pin cleared without match");
endmodule
`default_nettype wire

// ===== cpw_channel_bench.sv
// self-checking bench of the pwm channel
// assumes the design files and the load model compile before it
`default_nettype none
`include "cpw_defines.svh"
module cpw_channel_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic por_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic pwm_output_pin_out;
  logic [15:0] per_s;
  logic [15:0] high_s;
  logic [15:0] rises_s;
  int err_total = 0;
  int checks = 0;
  always #50 clk_in = ~clk_in;
  cpw_channel dut_u (.clk_in(clk_in), .reset_in(reset_in), .por_in(por_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pwm_output_pin_out(pwm_output_pin_out));
  cpw_load_model load_u (.clk_in(clk_in), .reset_in(reset_in),
    .pin_in(pwm_output_pin_out), .period_out(per_s), .high_out(high_s),
    .rises_out(rises_s));
  task automatic give_verdict;
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(what, {8'h00, rdata_out}, {8'h00, exp});
  endtask
  // bounded wait, a stuck pin counts as a mismatch
  task automatic wait_rises(input int n);
    logic [15:0] base;
    int i;
    base = rises_s;
    for (i = 0; i < 3000 && rises_s < base + n; i++) @(posedge clk_in);
    chk("rises", {15'h0000, rises_s >= base + n}, 16'h0001);
  endtask
  task automatic hold_chk(input logic v);
    logic bad;
    bad = 1'b0;
    repeat (40) @(negedge clk_in) if (pwm_output_pin_out !== v) bad = 1'b1;
    chk("pin level", {15'h0000, bad}, 16'h0000);
  endtask
  task automatic reset_values;
    rd_chk("control", `CPW_ADDR_CONTROL, 8'h00);
    rd_chk("period a", `CPW_ADDR_PERIOD_A, 8'hff);
    rd_chk("tb config", `CPW_ADDR_TB_CONFIG, 8'h00);
    rd_chk("unmapped", 3'h7, 8'h00);
  endtask
  task automatic top_bits;
    wr(`CPW_ADDR_CONTROL, 8'hf0);
    rd_chk("control top", `CPW_ADDR_CONTROL, 8'h30);
    // slave byte is unknown after power up; give it a value outside pwm mode
    wr(`CPW_ADDR_DUTY_SLAVE, 8'h5a);
    rd_chk("slave writable", `CPW_ADDR_DUTY_SLAVE, 8'h5a);
  endtask
  task automatic run_pwm(input logic [2:0] pa, input logic [7:0] per, input logic [7:0] cfg,
      input logic [15:0] ep, input logic [15:0] eh);
    wr(pa, per);
    wr(`CPW_ADDR_DUTY_MASTER, 8'h02);
    wr(`CPW_ADDR_CONTROL, 8'h1c);
    wr(`CPW_ADDR_TB_CONFIG, cfg);
    wait_rises(3);
    chk("period", per_s, ep);
    chk("high time", high_s, eh);
  endtask
  task automatic pwm_shapes;
    // duty 2:01 is nine quarter ticks
    run_pwm(`CPW_ADDR_PERIOD_A, 8'h03, 8'h02, 16'd16, 16'd9);
    run_pwm(`CPW_ADDR_PERIOD_A, 8'h03, 8'h06, 16'd64, 16'd36);
    run_pwm(`CPW_ADDR_PERIOD_B, 8'h02, 8'h03, 16'd12, 16'd9);
    run_pwm(`CPW_ADDR_PERIOD_A, 8'h03, 8'h02, 16'd16, 16'd9);
  endtask
  task automatic duty_reload;
    wr(`CPW_ADDR_DUTY_MASTER, 8'h01);
    chk("old duty kept", high_s, 16'd9);
    wait_rises(3);
    chk("new duty", high_s, 16'd5);
    wr(`CPW_ADDR_DUTY_SLAVE, 8'haa);
    rd_chk("slave", `CPW_ADDR_DUTY_SLAVE, 8'h01);
  endtask
  task automatic duty_edges;
    wr(`CPW_ADDR_DUTY_MASTER, 8'h00);
    wr(`CPW_ADDR_CONTROL, 8'h0c);
    repeat (40) @(posedge clk_in);
    hold_chk(1'b0);
    wr(`CPW_ADDR_DUTY_MASTER, 8'h10);
    repeat (40) @(posedge clk_in);
    hold_chk(1'b1);
  endtask
  task automatic clear_control;
    wr(`CPW_ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge clk_in);
    hold_chk(1'b0);
  endtask
  task automatic soft_reset;
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rd_chk("master kept", `CPW_ADDR_DUTY_MASTER, 8'h10);
    rd_chk("control", `CPW_ADDR_CONTROL, 8'h00);
    chk("pin", {15'h0000, pwm_output_pin_out}, 16'h0000);
  endtask
  // whole run is well under the ten thousand cycles of the time limit
  initial begin
    #1000000;
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    por_in <= 1'b0;
    reset_values;
    top_bits;
    pwm_shapes;
    duty_reload;
    duty_edges;
    clear_control;
    soft_reset;
    give_verdict;
  end
endmodule
`default_nettype wire

// ===== cpw_defines.svh
// constants of the pwm output channel: offsets, fields, reset values
// assumes inclusion by bare name from the channel, time base and bench files
`ifndef CPW_DEFINES_SVH
`define CPW_DEFINES_SVH
`define CPW_ADDR_DUTY_MASTER 3'h0
`define CPW_ADDR_DUTY_SLAVE 3'h1
`define CPW_ADDR_CONTROL 3'h2
`define CPW_ADDR_PERIOD_A 3'h3
`define CPW_ADDR_PERIOD_B 3'h4
`define CPW_ADDR_TB_CONFIG 3'h5
`define CPW_ADDR_STATUS 3'h6
`define CPW_CTRL_RESET 8'h00
`define CPW_CTRL_IMPL_MASK 8'h3f
`define CPW_CTRL_DCLO_MSB 5
`define CPW_CTRL_DCLO_LSB 4
`define CPW_MODE_PWM_MSB 3
`define CPW_MODE_PWM_LSB 2
`define CPW_MODE_PWM_VAL 2'h3
`define CPW_PERIOD_RESET 8'hff
`define CPW_TBCFG_RESET 8'h00
`define CPW_TBCFG_SEL_BIT 0
`define CPW_TBCFG_ON_BIT 1
`define CPW_TBCFG_PS_MSB 3
`define CPW_TBCFG_PS_LSB 2
`define CPW_OSC_PER_TICK 3'h4
`endif

// ===== cpw_load_model.sv
// load on the pwm pin: measures period and high time between rising edges
// assumes one clock; the pin is sampled on its rising edge
`default_nettype none
module cpw_load_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic [15:0] period_out,
  output logic [15:0] high_out,
  output logic [15:0] rises_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q;
  logic [15:0] run_q;
  logic [15:0] hi_q;
  // pin taken as a driven output, direction bit cleared
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prev_q <= 1'b0;
      run_q <= 16'h0000;
      hi_q <= 16'h0000;
      period_out <= 16'h0000;
      high_out <= 16'h0000;
      rises_out <= 16'h0000;
    end else begin
      prev_q <= pin_in;
      if (pin_in && !prev_q) begin
        period_out <= run_q;
        high_out <= hi_q;
        rises_out <= rises_out + 16'h0001;
        run_q <= 16'h0001;
        hi_q <= 16'h0001;
      end else begin
        run_q <= run_q + 16'h0001;
        hi_q <= hi_q + {15'h0000, pin_in};
      end
    end
  end
endmodule
`default_nettype wire

// ===== cpw_pkg.sv
// types shared by the pwm output channel
// assumes the defines header is compiled alongside
`default_nettype none
package cpw_pkg;
  typedef enum logic [2:0] {
    CPW_OFF = 3'b001,
    CPW_HIGH = 3'b010,
    CPW_LOW = 3'b100
  } cpw_state_t;
  typedef enum logic [1:0] {
    CPW_PS1 = 2'h0,
    CPW_PS4 = 2'h1,
    CPW_PS16 = 2'h2
  } cpw_prescale_t;
endpackage
`default_nettype wire

// ===== cpw_time_base.sv
// one 8-bit time base with period register, prescaler and quarter-cycle clock
// assumes one clock edge per oscillator period; control comes from the channel top
`default_nettype none
`include "cpw_defines.svh"
module cpw_time_base (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic [1:0] prescale_in,
  input wire logic [7:0] period_in,
  output logic [7:0] count_out,
  output logic [1:0] fine_out,
  output logic rollover_out
);
  logic [1:0] quarter_q;
  logic [3:0] pre_q;
  logic [3:0] pre_max;
  logic tick;

  always_comb begin
    case (prescale_in)
      cpw_pkg::CPW_PS1: pre_max = 4'h0;
      cpw_pkg::CPW_PS4: pre_max = 4'h3;
      default: pre_max = 4'hf;
    endcase
  end

  // four oscillator periods make one instruction tick
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      quarter_q <= 2'h0;
    end else begin
      quarter_q <= quarter_q + 2'h1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pre_q <= 4'h0;
    end else if (!enable_in) begin
      pre_q <= 4'h0;
    end else if (quarter_q == 2'h3) begin
      pre_q <= (pre_q >= pre_max) ? 4'h0 : pre_q + 4'h1;
    end
  end

  assign tick = enable_in && (quarter_q == 2'h3) && (pre_q >= pre_max);
  assign rollover_out = tick && (count_out == period_in);

  // clear on the increment after a period match
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_out <= 8'h00;
    end else if (tick) begin
      count_out <= (count_out == period_in) ? 8'h00 : count_out + 8'h01; // see [RULE5]
    end
  end

  // low extension bits: quarter clock at prescale 1, else prescaler bits
  always_comb begin
    case (prescale_in)
      cpw_pkg::CPW_PS1: fine_out = quarter_q; // see [RULE12]
      cpw_pkg::CPW_PS4: fine_out = pre_q[1:0];
      default: fine_out = pre_q[3:2];
    endcase
  end
endmodule
`default_nettype wire
